/* rtl/hcr_pkg.sv */
package hcr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register map, one byte per address
	localparam int unsigned NUM_REGS                 = 256;
	localparam logic [7:0] A_VENDOR_ID_LOW           = 8'h00;
	localparam logic [7:0] A_VENDOR_ID_HIGH          = 8'h01;
	localparam logic [7:0] A_PRODUCT_ID_LOW          = 8'h02;
	localparam logic [7:0] A_PRODUCT_ID_HIGH         = 8'h03;
	localparam logic [7:0] A_RELEASE_NUMBER_LOW      = 8'h04;
	localparam logic [7:0] A_RELEASE_NUMBER_HIGH     = 8'h05;
	localparam logic [7:0] A_CONFIG_BYTE_ONE         = 8'h06;
	localparam logic [7:0] A_CONFIG_BYTE_TWO         = 8'h07;
	localparam logic [7:0] A_CONFIG_BYTE_THREE       = 8'h08;
	localparam logic [7:0] A_NON_REMOVABLE_PORTS     = 8'h09;
	localparam logic [7:0] A_PORT_DISABLE_SELF       = 8'h0a;
	localparam logic [7:0] A_PORT_DISABLE_BUS        = 8'h0b;
	localparam logic [7:0] A_MAX_POWER_SELF          = 8'h0c;
	localparam logic [7:0] A_MAX_POWER_BUS           = 8'h0d;
	localparam logic [7:0] A_CONTROLLER_CURRENT_SELF = 8'h0e;
	localparam logic [7:0] A_CONTROLLER_CURRENT_BUS  = 8'h0f;
	localparam logic [7:0] A_POWER_ON_TIME           = 8'h10;
	localparam logic [7:0] A_LANGUAGE_CODE_HIGH      = 8'h11;
	localparam logic [7:0] A_LANGUAGE_CODE_LOW       = 8'h12;
	localparam logic [7:0] A_MAKER_STRING_LENGTH     = 8'h13;
	localparam logic [7:0] A_PRODUCT_STRING_LENGTH   = 8'h14;
	localparam logic [7:0] A_SERIAL_STRING_LENGTH    = 8'h15;
	localparam logic [7:0] A_MAKER_STRING_BYTES      = 8'h16;
	localparam logic [7:0] A_PRODUCT_STRING_BYTES    = 8'h54;
	localparam logic [7:0] A_SERIAL_STRING_BYTES     = 8'h92;
	localparam logic [7:0] A_BATTERY_CHARGE_ENABLE   = 8'hd0;
	localparam logic [7:0] A_RESERVED_FIRST          = 8'hd1;
	localparam logic [7:0] A_PORT_POWER_STATUS       = 8'he5;
	localparam logic [7:0] A_OVERCURRENT_SENSE       = 8'he6;
	localparam logic [7:0] A_SERIAL_INTERLOCK        = 8'he7;
	localparam logic [7:0] A_INTERRUPT_FLAGS         = 8'he8;
	localparam logic [7:0] A_INTERRUPT_ENABLE_MASK   = 8'he9;
	localparam logic [7:0] A_PORTABLE_HUB_CONFIG     = 8'hee;
	localparam logic [7:0] A_RX_SENSITIVITY_UP_P3    = 8'hf4;
	localparam logic [7:0] A_RX_SENSITIVITY_P2_P1    = 8'hf5;
	localparam logic [7:0] A_TX_DRIVE_UP_P3          = 8'hf6;
	localparam logic [7:0] A_TX_DRIVE_P2_P1          = 8'hf8;
	localparam logic [7:0] A_LANE_POLARITY_SWAP      = 8'hfa;
	localparam logic [7:0] A_PORT_REMAP_FIRST_PAIR   = 8'hfb;
	localparam logic [7:0] A_PORT_REMAP_SECOND_PAIR  = 8'hfc;
	localparam logic [7:0] A_SERIAL_COMMAND_STATUS   = 8'hff;

	// Reset values; identity bytes come from top-level parameters
	localparam logic [7:0] DEF_CONFIG_BYTE_ONE       = 8'h98;
	localparam logic [7:0] DEF_OTHER                 = 8'h00;
	localparam int unsigned CONFIG_BYTE_ONE_MULTI_TT_BIT        = 7;

	////////////////////////////////////////////////////////////////////////////
	// Transaction translator buffer plan, in bytes
	localparam logic [10:0] TT_PERIODIC_BYTES        = 11'h5e8;
	localparam logic [10:0] TT_NON_PERIODIC_BYTES    = 11'h110;
	localparam logic [10:0] TT_SS_DESC_BYTES         = 11'h100;
	localparam logic [10:0] TT_SS_DATA_BYTES         = 11'h2f0;
	localparam logic [10:0] TT_CS_DESC_BYTES         = 11'h080;
	localparam logic [10:0] TT_CS_DATA_BYTES         = 11'h178;
	localparam logic [10:0] TT_NP_DESC_BYTES         = 11'h010;
	localparam logic [10:0] TT_NP_DATA_BYTES         = 11'h100;
	localparam logic [2:0]  TT_NP_BUFFERS            = 3'h4;
	localparam logic [1:0]  TT_SINGLE_COUNT          = 2'h1;

	// Serial slave framing
	localparam logic [3:0]  BITS_PER_BYTE            = 4'h8;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef logic [NUM_REGS-1:0][7:0] hcr_image_t;

	typedef enum logic [2:0] {
		SER_IDLE     = 3'h0,
		SER_ADDR     = 3'h1,
		SER_ACK_ADDR = 3'h2,
		SER_PTR      = 3'h3,
		SER_WDATA    = 3'h4,
		SER_ACK_DATA = 3'h5,
		SER_RDATA    = 3'h6,
		SER_RACK     = 3'h7
	} hcr_ser_st_t;

	typedef struct packed {
		hcr_ser_st_t st;
		logic [3:0]  bitcnt;
		logic [7:0]  shift;
		logic [7:0]  ptr;
		logic        rw;
		logic        nack;
		logic        prev_scl;
		logic        prev_sda;
		logic        sda_oe;
		logic        sda_lo;
		logic        any_write;
		hcr_image_t  mem;
	} hcr_bank_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} hcr_sync_t;

	typedef struct packed {
		logic [1:0]  tt_count;
		logic [10:0] ss_desc;
		logic [10:0] ss_data;
		logic [10:0] cs_desc;
		logic [10:0] cs_data;
		logic [10:0] np_desc;
		logic [10:0] np_data;
		logic [2:0]  np_buffers;
	} hcr_tt_plan_t;

	////////////////////////////////////////////////////////////////////////////
	// Which addresses hold a writable byte; reserved ones hold nothing
	function automatic logic reg_writable(input logic [7:0] a);
		logic ok;
		ok = (a <= A_BATTERY_CHARGE_ENABLE);
		case (a)
			A_OVERCURRENT_SENSE, A_SERIAL_INTERLOCK, A_INTERRUPT_FLAGS,
			A_INTERRUPT_ENABLE_MASK, A_PORTABLE_HUB_CONFIG,
			A_RX_SENSITIVITY_UP_P3, A_RX_SENSITIVITY_P2_P1, A_TX_DRIVE_UP_P3,
			A_TX_DRIVE_P2_P1, A_LANE_POLARITY_SWAP, A_PORT_REMAP_FIRST_PAIR,
			A_PORT_REMAP_SECOND_PAIR, A_SERIAL_COMMAND_STATUS: ok = 1'b1;
			default: ;
		endcase
		return ok;
	endfunction

	// Built-in register image used at reset
	function automatic hcr_image_t reset_image(input logic [15:0] vid,
		input logic [15:0] pid, input logic [15:0] rel);
		hcr_image_t img;
		img = '{default: DEF_OTHER};
		img[A_VENDOR_ID_LOW]       = vid[7:0];
		img[A_VENDOR_ID_HIGH]      = vid[15:8];
		img[A_PRODUCT_ID_LOW]      = pid[7:0];
		img[A_PRODUCT_ID_HIGH]     = pid[15:8];
		img[A_RELEASE_NUMBER_LOW]  = rel[7:0];
		img[A_RELEASE_NUMBER_HIGH] = rel[15:8];
		img[A_CONFIG_BYTE_ONE]     = DEF_CONFIG_BYTE_ONE;
		return img;
	endfunction

endpackage

/* rtl/hcr_pin_sync.sv */
`timescale 1ns/10ps
module hcr_pin_sync #(
	parameter logic IDLE_LEVEL = 1'b1
) (
	input  wire logic clock_in,
	input  wire logic rstn_in,
	input  wire logic ce_in,
	input  wire logic pin_in,
	output logic      level_out
);

	hcr_pkg::hcr_sync_t st_ff;
	hcr_pkg::hcr_sync_t nxt_st;

	////////////////////////////////////////////////////////////////////////////
	// Three stages; the level moves only when stages two and three agree,
	// which also rejects a one-cycle glitch on the pin
	always_comb begin
		nxt_st = st_ff;
		if (ce_in) begin
			nxt_st.s1 = pin_in;
			nxt_st.s2 = st_ff.s1;
			nxt_st.s3 = st_ff.s2;
			if (st_ff.s2 == st_ff.s3) begin
				nxt_st.level = st_ff.s3;
			end
		end
	end

	// Reset to the idle bus level so no false edge follows release
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_ff <= '{s1: IDLE_LEVEL, s2: IDLE_LEVEL, s3: IDLE_LEVEL, level: IDLE_LEVEL};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign level_out = st_ff.level;

endmodule

/* rtl/hcr_tt_plan.sv */
`timescale 1ns/10ps
module hcr_tt_plan #(
	parameter logic [1:0] PORTS = 2'h3
) (
	input  wire logic            clock_in,
	input  wire logic            rstn_in,
	input  wire logic            ce_in,
	input  wire logic            multi_tt_in,
	output hcr_pkg::hcr_tt_plan_t plan_out
);

	hcr_pkg::hcr_tt_plan_t st_ff;
	hcr_pkg::hcr_tt_plan_t nxt_st;

	////////////////////////////////////////////////////////////////////////////
	// Every translator gets the same split whether shared or per port
	always_comb begin
		nxt_st = st_ff;
		if (ce_in) begin
			nxt_st.tt_count   = multi_tt_in ? PORTS : hcr_pkg::TT_SINGLE_COUNT;
			nxt_st.ss_desc    = hcr_pkg::TT_SS_DESC_BYTES;
			nxt_st.ss_data    = hcr_pkg::TT_SS_DATA_BYTES;
			nxt_st.cs_desc    = hcr_pkg::TT_CS_DESC_BYTES;
			nxt_st.cs_data    = hcr_pkg::TT_CS_DATA_BYTES;
			nxt_st.np_desc    = hcr_pkg::TT_NP_DESC_BYTES;
			nxt_st.np_data    = hcr_pkg::TT_NP_DATA_BYTES;
			nxt_st.np_buffers = hcr_pkg::TT_NP_BUFFERS;
		end
	end

	// Reset to the single shared translator until the image is read
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_ff <= '{tt_count: hcr_pkg::TT_SINGLE_COUNT, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign plan_out = st_ff;

	////////////////////////////////////////////////////////////////////////////
	// Checks on the plan
	property p_multi_count;
		@(posedge clock_in) disable iff (!rstn_in)
		(ce_in && multi_tt_in) |=> (plan_out.tt_count == PORTS);
	endproperty
	a_multi_count: assert property (p_multi_count) else $error("multi mode lacks one translator per port");

	property p_single_count;
		@(posedge clock_in) disable iff (!rstn_in)
		(ce_in && !multi_tt_in) |=> (plan_out.tt_count == 2'h1) && (plan_out.np_buffers == 3'h4);
	endproperty
	a_single_count: assert property (p_single_count) else $error("single mode translator count wrong");

	property p_buffer_sizes;
		@(posedge clock_in) disable iff (!rstn_in)
		ce_in |=> (11'(plan_out.ss_desc + plan_out.ss_data + plan_out.cs_desc + plan_out.cs_data) == 11'd1512)
			&& (11'(plan_out.np_desc + plan_out.np_data) == 11'd272);
	endproperty
	a_buffer_sizes: assert property (p_buffer_sizes) else $error("translator buffer areas wrong size");

	property p_np_split;
		@(posedge clock_in) disable iff (!rstn_in)
		ce_in |=> (plan_out.np_buffers == 3'h4) [*2];
	endproperty
	a_np_split: assert property (p_np_split) else $error("non-periodic area not split in four");

	property p_partition;
		@(posedge clock_in) disable iff (!rstn_in)
		ce_in |=> (plan_out.ss_data == 11'd752) && (plan_out.cs_data == 11'd376) && (plan_out.np_desc == 11'd16)
			&& (plan_out.cs_desc == 11'd128);
	endproperty
	a_partition: assert property (p_partition) else $error("translator partition wrong");

endmodule

/* rtl/hcr_config_bank.sv */
// Summary of operation
// - Configuration comes from serial writes or from built-in defaults when nobody writes.
// - A register never written keeps its default and is used with it, except port power status, which tracks the switches.
// - Multi translator mode gives every downstream port its own translator.
// - Each translator owns 1512 periodic bytes and 272 non-periodic bytes.
// - The non-periodic area of each translator splits into four buffers.
// - Single mode shares one translator with the same buffer sizes.
// - Buffer split: 256, 752, 128, 376, 16 and 256 bytes in order.
// - Port power status is read-only; the other mapped registers read and write.
// - Hardware reset returns every register to default; nothing survives standby.
`timescale 1ns/10ps
module hcr_config_bank #(
	parameter logic [6:0]  DEV_ADDR    = 7'h2d,
	parameter logic [15:0] VENDOR_ID   = 16'h1234, // Arbitrary identity value
	parameter logic [15:0] PRODUCT_ID  = 16'h5678, // Arbitrary identity value
	parameter logic [15:0] RELEASE_NUM = 16'h0100, // Arbitrary identity value
	parameter logic [1:0]  PORTS       = 2'h3
) (
	input  wire logic                   clock_in,
	input  wire logic                   rstn_in,
	input  wire logic                   ce_in,
	input  wire logic                   scl_in,
	input  wire logic                   sda_in,
	output logic                        sda_out,
	output logic                        sda_oe_out,
	input  wire logic [7:0]             port_power_in,
	output hcr_pkg::hcr_image_t         image_out,
	output hcr_pkg::hcr_tt_plan_t       tt_plan_out
);

	localparam hcr_pkg::hcr_image_t RESET_IMAGE = hcr_pkg::reset_image(VENDOR_ID, PRODUCT_ID, RELEASE_NUM);

	hcr_pkg::hcr_bank_t st_ff;
	hcr_pkg::hcr_bank_t nxt_st;
	logic               scl_lvl;
	logic               sda_lvl;
	logic               scl_rise;
	logic               scl_fall;
	logic               bus_start;
	logic               bus_stop;
	logic               byte_done;
	logic               wr_en;

	////////////////////////////////////////////////////////////////////////////
	// Pin conditioning: both serial lines come from another domain
	hcr_pin_sync #(
		.IDLE_LEVEL (1'b1)
	) u_scl_sync (
		.clock_in  (clock_in),
		.rstn_in   (rstn_in),
		.ce_in     (ce_in),
		.pin_in    (scl_in),
		.level_out (scl_lvl)
	);

	hcr_pin_sync #(
		.IDLE_LEVEL (1'b1)
	) u_sda_sync (
		.clock_in  (clock_in),
		.rstn_in   (rstn_in),
		.ce_in     (ce_in),
		.pin_in    (sda_in),
		.level_out (sda_lvl)
	);

	// Translator sizing follows the multi-translator bit of config byte one
	hcr_tt_plan #(
		.PORTS (PORTS)
	) u_tt_plan (
		.clock_in    (clock_in),
		.rstn_in     (rstn_in),
		.ce_in       (ce_in),
		.multi_tt_in (st_ff.mem[hcr_pkg::A_CONFIG_BYTE_ONE][hcr_pkg::CONFIG_BYTE_ONE_MULTI_TT_BIT]),
		.plan_out    (tt_plan_out)
	);

	////////////////////////////////////////////////////////////////////////////
	// Bus events from the conditioned levels
	always_comb begin
		scl_rise  = scl_lvl & ~st_ff.prev_scl;
		scl_fall  = ~scl_lvl & st_ff.prev_scl;
		bus_start = scl_lvl & st_ff.prev_scl & st_ff.prev_sda & ~sda_lvl;
		bus_stop  = scl_lvl & st_ff.prev_scl & ~st_ff.prev_sda & sda_lvl;
		byte_done = scl_fall && (st_ff.bitcnt == hcr_pkg::BITS_PER_BYTE);
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial slave and register image. Data is sampled on the rising clock
	// and the line is only changed on the falling clock, so the master never
	// sees a data change while the clock is high.
	always_comb begin
		nxt_st = st_ff;
		wr_en  = 1'b0;
		if (ce_in) begin
			nxt_st.prev_scl = scl_lvl;
			nxt_st.prev_sda = sda_lvl;
			// Status byte tracks the port power switches on every enabled cycle
			nxt_st.mem[hcr_pkg::A_PORT_POWER_STATUS] = port_power_in;
			if (bus_start) begin
				nxt_st.st     = hcr_pkg::SER_ADDR;
				nxt_st.bitcnt = '0;
				nxt_st.sda_oe = 1'b0;
			end else if (bus_stop) begin
				nxt_st.st     = hcr_pkg::SER_IDLE;
				nxt_st.sda_oe = 1'b0;
			end else begin
				case (st_ff.st)
					hcr_pkg::SER_IDLE: begin
						nxt_st.sda_oe = 1'b0;
					end
					hcr_pkg::SER_ADDR, hcr_pkg::SER_PTR, hcr_pkg::SER_WDATA: begin
						// Shift one bit per rising clock, MSB first
						if (scl_rise && (st_ff.bitcnt < hcr_pkg::BITS_PER_BYTE)) begin
							nxt_st.shift  = {st_ff.shift[6:0], sda_lvl};
							nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
						end
						if (byte_done) begin
							nxt_st.bitcnt = '0;
							if (st_ff.st == hcr_pkg::SER_ADDR) begin
								// Only our own address is acknowledged
								if (st_ff.shift[7:1] == DEV_ADDR) begin
									nxt_st.rw     = st_ff.shift[0];
									nxt_st.sda_oe = 1'b1;
									nxt_st.st     = hcr_pkg::SER_ACK_ADDR;
								end else begin
									nxt_st.st = hcr_pkg::SER_IDLE;
								end
							end else if (st_ff.st == hcr_pkg::SER_PTR) begin
								nxt_st.ptr    = st_ff.shift;
								nxt_st.sda_oe = 1'b1;
								nxt_st.st     = hcr_pkg::SER_ACK_DATA;
							end else begin
								// Reserved and read-only bytes take the
								// write cycle but keep their content
								wr_en = 1'b1;
								if (hcr_pkg::reg_writable(st_ff.ptr)) begin
									nxt_st.mem[st_ff.ptr] = st_ff.shift;
									nxt_st.any_write      = 1'b1;
								end
								nxt_st.ptr    = st_ff.ptr + 8'h01;
								nxt_st.sda_oe = 1'b1;
								nxt_st.st     = hcr_pkg::SER_ACK_DATA;
							end
						end
					end
					hcr_pkg::SER_ACK_ADDR: begin
						if (scl_fall) begin
							nxt_st.bitcnt = '0;
							if (st_ff.rw) begin
								// Read starts at the pointer left by the last write or read
								nxt_st.shift  = st_ff.mem[st_ff.ptr];
								nxt_st.sda_oe = ~st_ff.mem[st_ff.ptr][7];
								nxt_st.st     = hcr_pkg::SER_RDATA;
							end else begin
								nxt_st.sda_oe = 1'b0;
								nxt_st.st     = hcr_pkg::SER_PTR;
							end
						end
					end
					hcr_pkg::SER_ACK_DATA: begin
						if (scl_fall) begin
							nxt_st.sda_oe = 1'b0;
							nxt_st.bitcnt = '0;
							nxt_st.st     = hcr_pkg::SER_WDATA;
						end
					end
					hcr_pkg::SER_RDATA: begin
						if (scl_rise) begin
							nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
						end
						if (byte_done) begin
							// Release for the master's acknowledge
							nxt_st.sda_oe = 1'b0;
							nxt_st.bitcnt = '0;
							nxt_st.ptr    = st_ff.ptr + 8'h01;
							nxt_st.st     = hcr_pkg::SER_RACK;
						end else if (scl_fall) begin
							nxt_st.shift  = {st_ff.shift[6:0], 1'b0};
							nxt_st.sda_oe = ~st_ff.shift[6];
						end
					end
					hcr_pkg::SER_RACK: begin
						if (scl_rise) begin
							nxt_st.nack = sda_lvl;
						end
						if (scl_fall) begin
							if (st_ff.nack) begin
								nxt_st.st = hcr_pkg::SER_IDLE;
							end else begin
								nxt_st.shift  = st_ff.mem[st_ff.ptr];
								nxt_st.sda_oe = ~st_ff.mem[st_ff.ptr][7];
								nxt_st.st     = hcr_pkg::SER_RDATA;
							end
						end
					end
					default: begin
						nxt_st.st     = hcr_pkg::SER_IDLE;
						nxt_st.sda_oe = 1'b0;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register; reset reloads the whole built-in image, so no setting
	// outlives a reset or a pass through standby
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_ff          <= '0;
			st_ff.prev_scl <= 1'b1;
			st_ff.prev_sda <= 1'b1;
			st_ff.mem      <= RESET_IMAGE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Open drain: the line is only ever pulled low
	assign sda_out    = st_ff.sda_lo;
	assign sda_oe_out = st_ff.sda_oe;
	assign image_out  = st_ff.mem;

	////////////////////////////////////////////////////////////////////////////
	// Checks on the register image
	property p_status_mirror;
		@(posedge clock_in) disable iff (!rstn_in)
		ce_in |=> (image_out[hcr_pkg::A_PORT_POWER_STATUS] == $past(port_power_in));
	endproperty
	a_status_mirror: assert property (p_status_mirror) else $error("port power status not read-only mirror");

	property p_untouched_default;
		@(posedge clock_in) disable iff (!rstn_in)
		!st_ff.any_write |-> (image_out[hcr_pkg::A_CONFIG_BYTE_ONE] == 8'h98)
			&& (image_out[hcr_pkg::A_VENDOR_ID_LOW] == VENDOR_ID[7:0]);
	endproperty
	a_untouched_default: assert property (p_untouched_default) else $error("default lost without a write");

	property p_keep_unwritten;
		@(posedge clock_in) disable iff (!rstn_in)
		!(wr_en && (st_ff.ptr == hcr_pkg::A_CONFIG_BYTE_TWO)) |=> $stable(image_out[hcr_pkg::A_CONFIG_BYTE_TWO]);
	endproperty
	a_keep_unwritten: assert property (p_keep_unwritten) else $error("register changed without a write");

	property p_byte_write;
		@(posedge clock_in) disable iff (!rstn_in)
		(ce_in && wr_en && hcr_pkg::reg_writable(st_ff.ptr)) |=>
			(image_out[$past(st_ff.ptr)] == $past(st_ff.shift)) && (st_ff.ptr == 8'($past(st_ff.ptr) + 8'h01));
	endproperty
	a_byte_write: assert property (p_byte_write) else $error("byte write not stored at pointer");

	property p_reserved_empty;
		@(posedge clock_in) disable iff (!rstn_in)
		(image_out[hcr_pkg::A_RESERVED_FIRST] == 8'h00) && (image_out[8'hfd] == 8'h00);
	endproperty
	a_reserved_empty: assert property (p_reserved_empty) else $error("reserved byte holds data");

	property p_ack_after_addr;
		@(posedge clock_in) disable iff (!rstn_in)
		(st_ff.st == hcr_pkg::SER_ACK_ADDR) |-> sda_oe_out;
	endproperty
	a_ack_after_addr: assert property (p_ack_after_addr) else $error("address acknowledge not driven");

	// A write aimed at the status byte must leave the live mirror in place
	property p_status_readonly;
		@(posedge clock_in) disable iff (!rstn_in)
		(wr_en && (st_ff.ptr == hcr_pkg::A_PORT_POWER_STATUS)) |=>
			(image_out[hcr_pkg::A_PORT_POWER_STATUS] == $past(port_power_in));
	endproperty
	a_status_readonly: assert property (p_status_readonly) else $error("status byte took a write");

	// Consecutive addressing runs off the top of the map back to zero
	property p_ptr_wrap;
		@(posedge clock_in) disable iff (!rstn_in)
		(wr_en && (st_ff.ptr == 8'hff)) |=> (st_ff.ptr == 8'h00);
	endproperty
	a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");

	// Another slave's address must leave the data line alone
	property p_foreign_ignored;
		@(posedge clock_in) disable iff (!rstn_in)
		(ce_in && (st_ff.st == hcr_pkg::SER_ADDR) && byte_done && (st_ff.shift[7:1] != DEV_ADDR)) |=>
			(st_ff.st == hcr_pkg::SER_IDLE) && !sda_oe_out;
	endproperty
	a_foreign_ignored: assert property (p_foreign_ignored) else $error("foreign address answered");

	// A stop always frees the line and ends the transfer
	property p_stop_idles;
		@(posedge clock_in) disable iff (!rstn_in)
		(ce_in && bus_stop) |=> (st_ff.st == hcr_pkg::SER_IDLE) && !sda_oe_out;
	endproperty
	a_stop_idles: assert property (p_stop_idles) else $error("stop did not end the transfer");

endmodule

/* tb/hcr_host_model.sv */
`timescale 1ns/10ps
module hcr_host_model (
	input  wire logic       clock_in,
	input  wire logic       sda_line_in,
	output logic            scl_out,
	output logic            sda_drv_out,
	output logic            res_valid_out,
	output logic [7:0]      res_out
);
	////////////////////////////////////////////////////////////////////////////
	// Idle bus with both lines released to the pull-up level
	initial begin
		scl_out = 1'b1;
		sda_drv_out = 1'b1;
		res_valid_out = 1'b0;
		res_out = 8'h00;
	end

	// Each phase lasts 8 core cycles, above the 5-cycle floor of the slave
	task automatic half();
		repeat (8) @(negedge clock_in);
	endtask

	// One-cycle result strobe for the bench watcher
	task automatic report(input logic [7:0] v);
		res_out = v;
		res_valid_out = 1'b1;
		@(negedge clock_in);
		res_valid_out = 1'b0;
	endtask

	// Data moves one cycle after the clock fell so no false start or stop is seen
	task automatic clk_bit(input logic b, output logic s);
		@(negedge clock_in);
		sda_drv_out = b;
		half();
		scl_out = 1'b1;
		half();
		s = sda_line_in;
		scl_out = 1'b0;
	endtask

	// Also serves as repeated start since data is raised while the clock is low
	task automatic start();
		@(negedge clock_in);
		sda_drv_out = 1'b1;
		half();
		scl_out = 1'b1;
		half();
		sda_drv_out = 1'b0;
		half();
		scl_out = 1'b0;
	endtask

	task automatic stop();
		@(negedge clock_in);
		sda_drv_out = 1'b0;
		half();
		scl_out = 1'b1;
		half();
		sda_drv_out = 1'b1;
		half();
	endtask

	// Master sends msb first, then releases data for the slave's acknowledge
	task automatic wr_byte(input logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(v[i], s);
		end
		clk_bit(1'b1, s);
		report({7'h00, ~s});
	endtask

	// Last byte of a read is refused so the slave stops driving
	task automatic rd_byte(input logic last);
		logic [7:0] v;
		logic       s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, s);
			v[i] = s;
		end
		clk_bit(last, s);
		report(v);
	endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
	localparam logic [7:0] ADDR_W = {7'h2d, 1'b0};
	localparam logic [7:0] ADDR_R = {7'h2d, 1'b1};
	logic                  clock_in, rstn_in, ce, scl, sda_drv, sda_out, sda_oe, res_valid, sda_line;
	logic [7:0]            port_power_in, res, lfsr_ff, a, b, c;
	hcr_pkg::hcr_image_t   image;
	hcr_pkg::hcr_tt_plan_t plan;
	logic [7:0]            exp_q[$];
	int                    num_errors, comparisons;

	////////////////////////////////////////////////////////////////////////////
	// Open-drain data line: low if either party pulls it
	assign sda_line = sda_drv & ~(sda_oe & ~sda_out);

	hcr_config_bank hcr_config_bank_inst (.clock_in(clock_in), .rstn_in(rstn_in), .ce_in(ce),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe),
		.port_power_in(port_power_in), .image_out(image), .tt_plan_out(plan));
	hcr_host_model hcr_host_model_inst (.clock_in(clock_in), .sda_line_in(sda_line), .scl_out(scl),
		.sda_drv_out(sda_drv), .res_valid_out(res_valid), .res_out(res));

	always #2.5 clock_in = ~clock_in;

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		if (num_errors == 0 && comparisons > 0 && exp_q.size() == 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Maximal-length shift register; the state advances on every call
	function automatic logic [7:0] rnd();
		lfsr_ff = {lfsr_ff[6:0], ^(lfsr_ff & 8'hb8)};
		return lfsr_ff;
	endfunction

	task automatic put_byte(input logic [7:0] v, input logic [7:0] ack);
		exp_q.push_back(ack);
		hcr_host_model_inst.wr_byte(v);
	endtask

	task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
		hcr_host_model_inst.start();
		put_byte(ADDR_W, 8'h01);
		put_byte(ptr, 8'h01);
		foreach (d[i]) put_byte(d[i], 8'h01);
		hcr_host_model_inst.stop();
	endtask

	task automatic rd(input logic [7:0] ptr, input logic [7:0] e[$]);
		hcr_host_model_inst.start();
		put_byte(ADDR_W, 8'h01);
		put_byte(ptr, 8'h01);
		hcr_host_model_inst.start();
		put_byte(ADDR_R, 8'h01);
		foreach (e[i]) begin
			exp_q.push_back(e[i]);
			hcr_host_model_inst.rd_byte(i == e.size() - 1);
		end
		hcr_host_model_inst.stop();
	endtask

	// Plan check: the six partitions must add up to the periodic and non-periodic areas
	task automatic check_plan(input logic [1:0] n);
		check(plan.tt_count, n);
		check(plan.ss_desc + plan.ss_data + plan.cs_desc + plan.cs_data, 16'h05e8);
		check(plan.np_desc + plan.np_data, 16'h0110);
		check({plan.ss_desc, plan.ss_data, plan.cs_desc}, {11'h100, 11'h2f0, 11'h080});
		check({plan.cs_data, plan.np_desc, plan.np_data}, {11'h178, 11'h010, 11'h100});
		check(plan.np_buffers, 16'h0004);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Watcher pairs each strobed result with the oldest note
	always @(posedge clock_in) begin
		if (res_valid === 1'b1)
			check({8'h00, res}, exp_q.size() > 0 ? {8'h00, exp_q.pop_front()} : 16'hffff);
	end

	// Whole run is near 9.4k cycles; the limit allows 40k
	initial begin
		#200000;
		num_errors++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////////
	// Main sequence, inputs move on the falling edge
	initial begin
		clock_in = 1'b0;
		rstn_in = 1'b0;
		port_power_in = 8'h00;
		ce = 1'b1;
		lfsr_ff = 8'h52;
		repeat (6) @(negedge clock_in);
		rstn_in = 1'b1;
		repeat (8) @(negedge clock_in);
		check_plan(2'h3);
		rd(8'h00, '{8'h34, 8'h12, 8'h78, 8'h56, 8'h00, 8'h01, 8'h98, 8'h00});
		a = rnd();
		b = rnd();
		c = rnd();
		wr(8'h07, '{a, b, c});
		check(image[8'h08], b);
		rd(8'h07, '{a, b, c, 8'h00});
		port_power_in = rnd();
		wr(8'he5, '{~port_power_in});
		rd(8'he5, '{port_power_in});
		a = rnd();
		b = rnd();
		wr(8'hff, '{a, b});
		rd(8'hff, '{a, b});
		// Reserved bytes are only ever read, never written
		rd(8'hfd, '{8'h00, 8'h00});
		wr(8'h06, '{8'h18});
		check_plan(2'h1);
		wr(8'h06, '{8'h98});
		check_plan(2'h3);
		// A low enable must freeze the mirror while the switches move
		c = port_power_in;
		ce = 1'b0;
		port_power_in = rnd();
		repeat (4) @(negedge clock_in);
		check(image[8'he5], c);
		ce = 1'b1;
		repeat (2) @(negedge clock_in);
		check(image[8'he5], port_power_in);
		// Foreign address must go unanswered
		hcr_host_model_inst.start();
		put_byte({7'h2c, 1'b0}, 8'h00);
		hcr_host_model_inst.stop();
		@(negedge clock_in);
		rstn_in = 1'b0;
		repeat (6) @(negedge clock_in);
		check(image[8'h07], 16'h0000);
		check(image[8'h00], 16'h0034);
		rstn_in = 1'b1;
		repeat (8) @(negedge clock_in);
		rd(8'h06, '{8'h98, 8'h00});
		repeat (20) @(negedge clock_in);
		end_sim();
	end
endmodule
